// ===== verilog/arsq_defines.svh
`ifndef ARSQ_DEFINES_SVH
`define ARSQ_DEFINES_SVH
// Timebase: 10 MHz clock, 0.5 ms tick
`define ARSQ_CLK_HZ 10000000
`define ARSQ_TICK_US 500
`define ARSQ_TICK_CYC ((`ARSQ_CLK_HZ / 1000000) * `ARSQ_TICK_US)
// Register byte offsets
`define ARSQ_OFF_CTRL 12'h000
`define ARSQ_OFF_STATUS 12'h004
`define ARSQ_OFF_REASON 12'h008
`define ARSQ_OFF_LOCKOUT 12'h00C
`define ARSQ_OFF_GRECLAIM 12'h010
`define ARSQ_OFF_SHOT 12'h100
// CTRL fields
`define ARSQ_CTRL_EN_BIT 0
`define ARSQ_CTRL_GREN_BIT 1
`define ARSQ_CTRL_MRST_LSB 2
`define ARSQ_CTRL_RST_BIT 4
`define ARSQ_CTRL_GRP_LSB 8
`define ARSQ_CTRL_RESET 32'h0000_0000
// Per-shot words: base + (grp*R*S + req*S + shot)*16 + word*4
`define ARSQ_SW_START 2'h0
`define ARSQ_SW_DEAD 2'h1
`define ARSQ_SW_ACT 2'h2
`define ARSQ_SW_RECL 2'h3
// Flag bits in start word
`define ARSQ_SF_EN_BIT 31
`define ARSQ_SF_DISC_BIT 30
`endif

// ===== verilog/arsq_pkg.sv
package arsq_pkg;
  typedef enum logic [3:0] {
    ST_READY, ST_START_DLY, ST_OPEN_WAIT, ST_DEAD, ST_CLOSE_WAIT,
    ST_ACTION, ST_RECLAIM, ST_LOCKOUT_DLY, ST_LOCKED
  } arsq_state_type;

  typedef struct packed {
    logic blocked;
    logic disabled;
    logic lockout_dly;
    logic cmd_blocked;
    logic status_bad;
    logic gen_reclaim;
    logic locked;
  } arsq_inhibit_type;

  typedef struct packed {
    logic lock_in;
    logic final_trip;
    logic not_ready;
    logic no_sync;
    logic open_to;
    logic close_to;
    logic req_in_greclaim;
    logic req_held_dead;
    logic critical;
    logic req_in_lockout;
    logic req_in_action;
  } arsq_lock_type;

  typedef struct packed {
    logic is_open;
    logic is_closed;
    logic bad_status;
    logic open_blocked;
    logic close_blocked;
    logic not_ready_fail;
    logic no_sync_fail;
    logic open_timeout;
    logic close_timeout;
    logic any_close_cmd;
  } arsq_brk_type;
endpackage

// ===== verilog/arsq_sequencer.sv
// Overview of operation
// - Disabled shots are skipped; enabled shots run with their own timer settings.
// - Start-sourced request must persist for the shot starting delay before opening.
// - Starting delay applies only to start-sourced requests, never to trip-sourced.
// - Trip-sourced request with nonzero starting delay is refused.
// - Dead time counts from breaker open; on expiry close the breaker.
// - After reclose, keep breaker closed until shot action time elapses.
// - New request during action time locks out during reclaim.
// - Zero action time disables arcing or discrimination phase.
// - Shot reclaim timer starts after dead time and breaker close.
// - New request during shot reclaim advances to the next shot.
// - Failure of last configured shot issues final trip, no reclose.
// - Inhibit on block, disable, lock-out delay, command block, bad status, reclaim, lock.
// - Inhibit returns to Ready once every inhibit cause clears.
// - Lock on lock input, final trip, breaker failures or timeouts.
// - Request during general reclaim forces Locked.
// - Request still held when dead time ends forces Locked.
// - Critical request forces Locked from any state.
// - Locked is left only by user reset input, manual close or reset command, per config.
// - When not Ready, expose the active inhibit and lock reasons.
// - Shot settings are per setting group; group change acts immediately.
// - Manual-reset config selects user reset, any close, or reset command.
// - Request during lock-out delay opens breaker and locks.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "arsq_defines.svh"
module arsq_sequencer
  import arsq_pkg::*;
#(
  parameter int NUM_REQ = 5,
  parameter int NUM_SHOT = 5,
  parameter int NUM_GRP = 8,
  parameter int TICK_CYC = `ARSQ_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_REQ-1:0] reclose_request_n,
  input wire logic [NUM_REQ-1:0] request_from_trip,
  input wire logic critical_request,
  input wire logic lock_input,
  input wire logic block_input,
  input wire logic recloser_enable_input,
  input wire logic user_reset_input,
  input wire arsq_brk_type brk_in,
  output logic brk_open_cmd,
  output logic brk_close_cmd,
  output logic final_trip,
  output logic ready,
  output logic inhibit,
  output logic locked,
  output logic running
);
  localparam int NW = NUM_GRP * NUM_REQ * NUM_SHOT * 4;
  localparam int RW = $clog2(NUM_REQ + 1);
  localparam int SW = $clog2(NUM_SHOT + 1);
  localparam int GW = $clog2(NUM_GRP);
  localparam int TW = $clog2(TICK_CYC + 1);

  initial begin
    if (NUM_REQ < 1 || NUM_REQ > 8 || NUM_SHOT < 1 || NUM_SHOT > 8 ||
        NUM_GRP < 1 || NUM_GRP > 8 || TICK_CYC < 1 || NW * 4 > 3840)
      $error("arsq_sequencer: unsupported parameters");
  end

  // Pin inputs double-synchronised; first stage read only by second
  localparam int NSYNC = 2 * NUM_REQ + 6 + $bits(arsq_brk_type);
  logic [NSYNC-1:0] sync1_r, sync2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {reclose_request_n, request_from_trip, critical_request, lock_input,
                  block_input, recloser_enable_input, user_reset_input, 1'b0, brk_in};
      sync2_r <= sync1_r;
    end
  end
  logic [NUM_REQ-1:0] req_s, trip_s;
  logic crit_s, lock_s, blk_s, en_s, urst_s;
  arsq_brk_type brk_s;
  assign {req_s, trip_s, crit_s, lock_s, blk_s, en_s, urst_s} =
    sync2_r[NSYNC-1:$bits(arsq_brk_type)+1];
  assign brk_s = sync2_r[$bits(arsq_brk_type)-1:0];

  // Settings memory, per group/request/shot/word
  logic [31:0] shot_mem [NW];

  typedef struct packed {
    arsq_state_type st;
    logic [RW-1:0] req;
    logic [SW-1:0] shot;
    logic [31:0] tmr;
    logic [TW-1:0] tick_cnt;
    logic gr_run;
    logic [31:0] gr_tmr;
    logic action_hit;
    logic [31:0] ctrl;
    logic [31:0] lockout_set;
    logic [31:0] greclaim_set;
    arsq_lock_type lock_why;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic open_cmd;
    logic close_cmd;
    logic ftrip;
    logic rdy;
    logic inh;
    logic lkd;
    logic run;
  } arsq_state_rec_type;

  arsq_state_rec_type s_r, s_nxt;

  function automatic int widx(input logic [GW-1:0] g, input int r, input int s,
                              input logic [1:0] w);
    widx = ((int'(g) * NUM_REQ + r) * NUM_SHOT + s) * 4 + int'(w);
  endfunction

  // First enabled shot at or after "from" for a request
  function automatic logic [SW-1:0] next_shot(input logic [GW-1:0] g, input int r,
                                               input int from);
    next_shot = SW'(NUM_SHOT);
    for (int i = NUM_SHOT - 1; i >= 0; i--)
      if (i >= from && shot_mem[widx(g, r, i, `ARSQ_SW_START)][`ARSQ_SF_EN_BIT])
        next_shot = SW'(i);
  endfunction

  // Lowest active request index
  function automatic logic [RW-1:0] first_req(input logic [NUM_REQ-1:0] v);
    first_req = RW'(NUM_REQ);
    for (int i = NUM_REQ - 1; i >= 0; i--)
      if (v[i])
        first_req = RW'(i);
  endfunction

  logic [GW-1:0] grp;
  logic tick, any_req, apb_wr, shot_hit;
  logic [RW-1:0] new_req;
  logic [SW-1:0] first_sh;
  logic [31:0] cur_dead, cur_act, cur_recl;
  arsq_inhibit_type inh_why;
  int sidx;

  assign grp = s_r.ctrl[`ARSQ_CTRL_GRP_LSB +: GW];
  assign tick = (s_r.tick_cnt == TW'(TICK_CYC - 1));
  assign any_req = |req_s;
  assign new_req = first_req(req_s);
  assign first_sh = (new_req < RW'(NUM_REQ)) ? next_shot(grp, int'(new_req), 0) : SW'(NUM_SHOT);
  assign sidx = (s_r.req < RW'(NUM_REQ) && s_r.shot < SW'(NUM_SHOT)) ?
                widx(grp, int'(s_r.req), int'(s_r.shot), 2'h0) : 0;
  // Active group read live, so a group switch acts at once
  assign cur_dead = shot_mem[sidx + 1];
  assign cur_act = shot_mem[sidx + 2];
  assign cur_recl = shot_mem[sidx + 3];
  // A write lands at the edge where the master sees pready
  assign apb_wr = psel && penable && pwrite && s_r.pready;
  assign shot_hit = paddr >= `ARSQ_OFF_SHOT && int'(paddr) < int'(`ARSQ_OFF_SHOT) + NW * 4;

  always_ff @(posedge pclk) begin
    if (apb_wr && shot_hit)
      shot_mem[(int'(paddr) - int'(`ARSQ_OFF_SHOT)) / 4] <= pwdata;
  end

  // Inhibit causes
  always_comb begin
    inh_why.blocked = blk_s;
    inh_why.disabled = !(en_s && s_r.ctrl[`ARSQ_CTRL_EN_BIT]);
    inh_why.lockout_dly = (s_r.st == ST_LOCKOUT_DLY);
    inh_why.cmd_blocked = brk_s.open_blocked || brk_s.close_blocked;
    inh_why.status_bad = brk_s.bad_status;
    inh_why.gen_reclaim = s_r.gr_run;
    inh_why.locked = (s_r.st == ST_LOCKED);
  end

  always_comb begin
    logic [31:0] tdec;
    logic expired, unlock;
    tdec = 32'h0;
    expired = 1'b0;
    unlock = 1'b0;
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.open_cmd = 1'b0;
    s_nxt.close_cmd = 1'b0;
    s_nxt.ctrl[`ARSQ_CTRL_RST_BIT] = 1'b0;
    s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + TW'(1);
    // Zero setting expires at the first tick
    tdec = (tick && s_r.tmr != 32'h0) ? s_r.tmr - 32'h1 : s_r.tmr;
    expired = tick && s_r.tmr == 32'h0;
    s_nxt.tmr = tdec;
    if (s_r.gr_run && tick) begin
      if (s_r.gr_tmr == 32'h0)
        s_nxt.gr_run = 1'b0;
      else
        s_nxt.gr_tmr = s_r.gr_tmr - 32'h1;
    end
    // Mode chooses the unlock source
    unique case (s_r.ctrl[`ARSQ_CTRL_MRST_LSB +: 2])
      2'h0: unlock = urst_s;
      2'h1: unlock = urst_s || brk_s.any_close_cmd;
      default: unlock = urst_s || s_r.ctrl[`ARSQ_CTRL_RST_BIT];
    endcase

    unique case (s_r.st)
      ST_READY: begin
        s_nxt.ftrip = 1'b0;
        if (any_req && !(inh_why != '0)) begin
          s_nxt.req = new_req;
          s_nxt.shot = first_sh;
          if (s_r.gr_run) begin
            s_nxt.lock_why.req_in_greclaim = 1'b1;
            s_nxt.st = ST_LOCKED;
          end else if (first_sh == SW'(NUM_SHOT)) begin
            s_nxt.st = ST_READY;
          end else if (trip_s[new_req]) begin
            // Trip source gets no start delay: a nonzero start setting refuses it
            if (shot_mem[widx(grp, int'(new_req), int'(first_sh), `ARSQ_SW_START)][29:0] != 30'h0)
              s_nxt.st = ST_READY;
            else begin
              s_nxt.st = ST_OPEN_WAIT;
              s_nxt.open_cmd = 1'b1;
            end
          end else begin
            s_nxt.st = ST_START_DLY;
            s_nxt.tmr = {2'h0, shot_mem[widx(grp, int'(new_req), int'(first_sh),
                                              `ARSQ_SW_START)][29:0]};
            s_nxt.tick_cnt = '0;
          end
        end else if (any_req && s_r.gr_run) begin
          s_nxt.lock_why.req_in_greclaim = 1'b1;
          s_nxt.st = ST_LOCKED;
        end
      end
      ST_START_DLY: begin
        if (!req_s[s_r.req])
          s_nxt.st = ST_READY;
        else if (expired) begin
          s_nxt.st = ST_OPEN_WAIT;
          s_nxt.open_cmd = 1'b1;
        end
      end
      ST_OPEN_WAIT: begin
        s_nxt.open_cmd = !brk_s.is_open;
        if (brk_s.is_open) begin
          s_nxt.st = ST_DEAD;
          s_nxt.tmr = cur_dead;
          s_nxt.tick_cnt = '0;
        end
      end
      ST_DEAD: begin
        if (expired) begin
          if (req_s[s_r.req]) begin
            s_nxt.lock_why.req_held_dead = 1'b1;
            s_nxt.st = ST_LOCKED;
          end else begin
            s_nxt.st = ST_CLOSE_WAIT;
            s_nxt.close_cmd = 1'b1;
          end
        end
      end
      ST_CLOSE_WAIT: begin
        s_nxt.close_cmd = !brk_s.is_closed;
        if (brk_s.is_closed) begin
          s_nxt.action_hit = 1'b0;
          s_nxt.tick_cnt = '0;
          if (cur_act != 32'h0) begin
            s_nxt.st = ST_ACTION;
            s_nxt.tmr = cur_act;
          end else begin
            s_nxt.st = ST_RECLAIM;
            s_nxt.tmr = cur_recl;
          end
        end
      end
      ST_ACTION: begin
        // Breaker held closed: no open issued while counting
        if (any_req)
          s_nxt.action_hit = 1'b1;
        if (expired) begin
          s_nxt.st = ST_RECLAIM;
          s_nxt.tmr = cur_recl;
          s_nxt.tick_cnt = '0;
        end
      end
      ST_RECLAIM: begin
        if (s_r.action_hit || (any_req && s_r.action_hit)) begin
          s_nxt.lock_why.req_in_action = 1'b1;
          s_nxt.st = ST_LOCKED;
        end else if (any_req) begin
          // Shot failed: next enabled shot or final trip
          s_nxt.shot = next_shot(grp, int'(s_r.req), int'(s_r.shot) + 1);
          if (next_shot(grp, int'(s_r.req), int'(s_r.shot) + 1) == SW'(NUM_SHOT)) begin
            s_nxt.ftrip = 1'b1;
            s_nxt.open_cmd = 1'b1;
            s_nxt.lock_why.final_trip = 1'b1;
            s_nxt.st = ST_LOCKED;
          end else begin
            s_nxt.st = ST_OPEN_WAIT;
            s_nxt.open_cmd = 1'b1;
          end
        end else if (expired) begin
          s_nxt.st = ST_LOCKOUT_DLY;
          s_nxt.tmr = s_r.lockout_set;
          s_nxt.tick_cnt = '0;
          if (s_r.ctrl[`ARSQ_CTRL_GREN_BIT]) begin
            s_nxt.gr_run = 1'b1;
            s_nxt.gr_tmr = s_r.greclaim_set;
          end
        end
      end
      ST_LOCKOUT_DLY: begin
        if (any_req) begin
          s_nxt.open_cmd = 1'b1;
          s_nxt.lock_why.req_in_lockout = 1'b1;
          s_nxt.st = ST_LOCKED;
        end else if (expired)
          s_nxt.st = ST_READY;
      end
      ST_LOCKED: begin
        if (unlock) begin
          s_nxt.st = ST_READY;
          s_nxt.lock_why = '0;
          s_nxt.ftrip = 1'b0;
        end
      end
      default: s_nxt.st = ST_LOCKED;
    endcase

    // Lock causes override any state; they win over an unlock
    if (lock_s || crit_s || brk_s.not_ready_fail || brk_s.no_sync_fail ||
        brk_s.open_timeout || brk_s.close_timeout) begin
      s_nxt.lock_why.lock_in = s_nxt.lock_why.lock_in | lock_s;
      s_nxt.lock_why.critical = s_nxt.lock_why.critical | crit_s;
      s_nxt.lock_why.not_ready = s_nxt.lock_why.not_ready | brk_s.not_ready_fail;
      s_nxt.lock_why.no_sync = s_nxt.lock_why.no_sync | brk_s.no_sync_fail;
      s_nxt.lock_why.open_to = s_nxt.lock_why.open_to | brk_s.open_timeout;
      s_nxt.lock_why.close_to = s_nxt.lock_why.close_to | brk_s.close_timeout;
      s_nxt.st = ST_LOCKED;
    end

    // Status outputs
    s_nxt.lkd = (s_nxt.st == ST_LOCKED);
    s_nxt.inh = (inh_why != '0) || (s_nxt.st inside {ST_LOCKED, ST_LOCKOUT_DLY});
    s_nxt.rdy = (s_nxt.st == ST_READY) && (inh_why == '0);
    s_nxt.run = !(s_nxt.st inside {ST_READY, ST_LOCKED, ST_LOCKOUT_DLY});

    // APB slave: one wait state, answer registered with pready
    if (psel && penable && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      if (pwrite) begin
        unique case (paddr)
          `ARSQ_OFF_CTRL, `ARSQ_OFF_LOCKOUT, `ARSQ_OFF_GRECLAIM: s_nxt.pslverr = 1'b0;
          `ARSQ_OFF_STATUS, `ARSQ_OFF_REASON: s_nxt.pslverr = 1'b1;
          default: s_nxt.pslverr = !shot_hit;
        endcase
      end else begin
        unique case (paddr)
          `ARSQ_OFF_CTRL: s_nxt.prdata = s_r.ctrl;
          `ARSQ_OFF_STATUS: s_nxt.prdata = {9'h000, 4'(s_r.st), 4'(s_r.shot), 4'(s_r.req),
                                            7'h00, s_r.run, s_r.lkd, s_r.inh, s_r.rdy};
          `ARSQ_OFF_REASON: s_nxt.prdata = {9'h000, inh_why, 5'h00, s_r.lock_why};
          `ARSQ_OFF_LOCKOUT: s_nxt.prdata = s_r.lockout_set;
          `ARSQ_OFF_GRECLAIM: s_nxt.prdata = s_r.greclaim_set;
          default: begin
            s_nxt.prdata = shot_hit ? shot_mem[(int'(paddr) - int'(`ARSQ_OFF_SHOT)) / 4] : 32'h0;
            s_nxt.pslverr = !shot_hit;
          end
        endcase
      end
    end
    if (apb_wr) begin
      case (paddr)
        `ARSQ_OFF_CTRL: s_nxt.ctrl = pwdata;
        `ARSQ_OFF_LOCKOUT: s_nxt.lockout_set = pwdata;
        `ARSQ_OFF_GRECLAIM: s_nxt.greclaim_set = pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{st: ST_READY, ctrl: `ARSQ_CTRL_RESET, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign brk_open_cmd = s_r.open_cmd;
  assign brk_close_cmd = s_r.close_cmd;
  assign final_trip = s_r.ftrip;
  assign ready = s_r.rdy;
  assign inhibit = s_r.inh;
  assign locked = s_r.lkd;
  assign running = s_r.run;
endmodule // arsq_sequencer
`default_nettype wire

// ===== dv/arsq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module arsq_checker
  import arsq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic critical_request,
  input wire logic lock_input,
  input wire logic block_input,
  input wire logic recloser_enable_input,
  input wire logic user_reset_input,
  input wire arsq_brk_type brk_in,
  input wire logic brk_open_cmd,
  input wire logic brk_close_cmd,
  input wire logic final_trip,
  input wire logic ready,
  input wire logic inhibit,
  input wire logic locked
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since anything that may legally unlock
  logic [3:0] since_r;
  logic [3:0] since_nxt;
  always_comb begin
    since_nxt = since_r;
    if (user_reset_input || brk_in.any_close_cmd || (psel && penable && pwrite)) begin
      since_nxt = 4'h0;
    end else if (since_r != 4'hF) begin
      since_nxt = since_r + 4'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_r <= 4'hF;
    end else begin
      since_r <= since_nxt;
    end
  end
  property p_ready_excl; ready |-> !inhibit && !locked; endproperty
  a_ready_excl: assert property (p_ready_excl) else $error("ready beside inhibit or lock");
  property p_lock_inh; locked |-> inhibit; endproperty
  a_lock_inh: assert property (p_lock_inh) else $error("locked without inhibit");
  property p_final_lock; final_trip |-> locked; endproperty
  a_final_lock: assert property (p_final_lock) else $error("final trip not locked");
  property p_final_noclose; final_trip |-> !brk_close_cmd; endproperty
  a_final_noclose: assert property (p_final_noclose) else $error("reclose after final");
  property p_crit; critical_request [*3] |-> ##[0:4] locked; endproperty
  a_crit: assert property (p_crit) else $error("critical did not lock");
  property p_lock_in; lock_input [*3] |-> ##[0:4] locked; endproperty
  a_lock_in: assert property (p_lock_in) else $error("lock input did not lock");
  property p_block; block_input [*3] |-> ##[0:4] inhibit; endproperty
  a_block: assert property (p_block) else $error("block did not inhibit");
  property p_enable; !recloser_enable_input [*3] |-> ##[0:4] inhibit; endproperty
  a_enable: assert property (p_enable) else $error("disable did not inhibit");
  property p_close_open; $rose(brk_close_cmd) |-> brk_in.is_open && !brk_open_cmd; endproperty
  a_close_open: assert property (p_close_open) else $error("close while not open");
  property p_unlock; $fell(locked) |-> since_r < 4'h8; endproperty
  a_unlock: assert property (p_unlock) else $error("unlock without cause");
endmodule // arsq_checker
bind arsq_sequencer arsq_checker u_arsq_checker (.pclk, .presetn, .psel, .penable, .pwrite,
  .critical_request, .lock_input, .block_input, .recloser_enable_input, .user_reset_input,
  .brk_in, .brk_open_cmd, .brk_close_cmd, .final_trip, .ready, .inhibit, .locked);
`default_nettype wire

// ===== dv/arsq_brk_model.sv
`timescale 1ns/1ps
`default_nettype none
module arsq_brk_model
  import arsq_pkg::*;
#(
  parameter int DLY = 3
) (
  input wire logic pclk,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire arsq_brk_type flt,
  output var arsq_brk_type brk
);
  logic closed_r = 1'b1;
  int cnt_r = 0;
  // Travel takes DLY+1 cycles; a manual close wins at once
  always @(posedge pclk) begin
    if (flt.any_close_cmd) begin
      closed_r <= 1'b1;
    end else if ((open_cmd && closed_r) || (close_cmd && !closed_r)) begin
      cnt_r <= (cnt_r == DLY) ? 0 : cnt_r + 1;
      if (cnt_r == DLY) begin
        closed_r <= close_cmd;
      end
    end else begin
      cnt_r <= 0;
    end
  end
  always_comb begin
    brk = flt;
    brk.is_open = !closed_r;
    brk.is_closed = closed_r;
    brk.any_close_cmd = close_cmd || flt.any_close_cmd;
  end
endmodule // arsq_brk_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import arsq_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} arsq_row_type;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, brk_open_cmd, brk_close_cmd, final_trip, ready, inhibit, locked;
  logic running;
  logic [4:0] reclose_request_n = 5'h00;
  logic [4:0] request_from_trip = 5'h1B;
  logic critical_request = 1'b0, lock_input = 1'b0, block_input = 1'b0;
  logic recloser_enable_input = 1'b0, user_reset_input = 1'b0;
  arsq_brk_type brk_in, flt = '0;
  int miscompares = 0, cmp_count = 0, n;
  arsq_row_type rows [7] = '{'{0, 12'h000, 0, 0, 0}, '{1, 12'h004, 0, 0, 1},
    '{1, 12'h008, 0, 0, 1}, '{0, 12'h0F0, 0, 0, 1}, '{1, 12'h000, 32'h0000_0011, 0, 0},
    '{0, 12'h000, 0, 32'h0000_0001, 0}, '{1, 12'h00C, 0, 0, 0}};
  // Per row: request, shot, enable, start, dead, action, reclaim (ticks)
  int cfg [6][7] = '{'{0, 0, 0, 0, 60, 0, 0}, '{0, 1, 1, 0, 5, 0, 2}, '{1, 0, 1, 5, 5, 0, 2},
    '{2, 0, 1, 20, 5, 2, 2}, '{3, 0, 1, 0, 5, 0, 2}, '{4, 0, 1, 0, 5, 0, 40}};
  always #50 pclk = ~pclk;
  arsq_sequencer #(.TICK_CYC(2)) u_arsq_sequencer (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .reclose_request_n, .request_from_trip,
    .critical_request, .lock_input, .block_input, .recloser_enable_input, .user_reset_input,
    .brk_in, .brk_open_cmd, .brk_close_cmd, .final_trip, .ready, .inhibit, .locked, .running);
  arsq_brk_model u_arsq_brk_model (.pclk, .open_cmd(brk_open_cmd), .close_cmd(brk_close_cmd),
    .flt, .brk(brk_in));
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi, input string m);
    cmp_count++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("BAD %0t %s took %0d", $time, m, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk({31'h0, pready}, 32'h1, "no pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, e}, 32'h0, "write refused");
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return brk_open_cmd;
      1: return brk_close_cmd;
      2: return ready;
      3: return locked;
      4: return inhibit;
      5: return final_trip;
      6: return brk_in.is_open;
      default: return brk_in.is_closed;
    endcase
  endfunction
  task automatic waitv(input int s, input logic v, output int k);
    k = 0;
    while (sig(s) !== v && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    chk({31'h0, sig(s)}, {31'h0, v}, "wait");
  endtask
  task automatic unlock;
    user_reset_input <= 1'b1;
    flt.any_close_cmd <= 1'b1;
    repeat (6) @(posedge pclk);
    user_reset_input <= 1'b0;
    flt.any_close_cmd <= 1'b0;
    waitv(3, 1'b0, n);
    waitv(2, 1'b1, n);
  endtask
  task automatic shot(input int q, output int nd);
    reclose_request_n[q] <= 1'b1;
    waitv(0, 1'b1, n);
    chk({31'h0, running}, 32'h1, "running");
    waitv(6, 1'b1, n);
    // Released at once so the dead time does not end with it held
    reclose_request_n[q] <= 1'b0;
    waitv(1, 1'b1, nd);
    waitv(7, 1'b1, n);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    finish_test;
  end
  initial begin
    logic [31:0] d;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w && !rows[i].e) chk(r, rows[i].x, "read");
      chk({31'h0, e}, {31'h0, rows[i].e}, "error flag");
    end
    $display("register test done");
    foreach (cfg[i]) begin
      for (int w = 0; w < 4; w++) begin
        d = 32'(cfg[i][3 + w]);
        if (w == 0) d[31] = cfg[i][2][0];
        wr(12'h100 + 12'((cfg[i][0] * 5 + cfg[i][1]) * 16 + w * 4), d);
      end
    end
    wr(12'h000, 32'h0000_0001);
    recloser_enable_input <= 1'b1;
    waitv(2, 1'b1, n);
    shot(0, n);
    chk_rng(n, 8, 18, "dead of second shot");
    waitv(2, 1'b1, n);
    $display("skip test done");
    reclose_request_n[2] <= 1'b1;
    repeat (10) @(posedge pclk);
    reclose_request_n[2] <= 1'b0;
    repeat (50) @(posedge pclk);
    chk({31'h0, brk_open_cmd}, 32'h0, "short start");
    reclose_request_n[2] <= 1'b1;
    waitv(0, 1'b1, n);
    chk_rng(n, 38, 50, "start delay");
    waitv(6, 1'b1, n);
    reclose_request_n[2] <= 1'b0;
    waitv(7, 1'b1, n);
    waitv(2, 1'b1, n);
    $display("start delay test done");
    reclose_request_n[1] <= 1'b1;
    repeat (60) @(posedge pclk);
    chk({31'h0, brk_open_cmd}, 32'h0, "trip with delay");
    reclose_request_n[1] <= 1'b0;
    waitv(2, 1'b1, n);
    $display("refusal test done");
    shot(4, n);
    reclose_request_n[4] <= 1'b1;
    waitv(5, 1'b1, n);
    chk({31'h0, locked}, 32'h1, "final lock");
    reclose_request_n[4] <= 1'b0;
    unlock;
    $display("final trip test done");
    reclose_request_n[3] <= 1'b1;
    waitv(6, 1'b1, n);
    waitv(3, 1'b1, n);
    reclose_request_n[3] <= 1'b0;
    repeat (20) @(posedge pclk);
    chk({31'h0, locked}, 32'h1, "lock holds");
    unlock;
    $display("held request test done");
    wr(12'h00C, 32'h0000_0028);
    shot(3, n);
    waitv(4, 1'b1, n);
    reclose_request_n[3] <= 1'b1;
    waitv(0, 1'b1, n);
    chk({31'h0, locked}, 32'h1, "lockout request");
    reclose_request_n[3] <= 1'b0;
    unlock;
    $display("lock-out delay test done");
    for (int i = 0; i < 2; i++) begin
      if (i == 0) block_input <= 1'b1;
      else recloser_enable_input <= 1'b0;
      waitv(4, 1'b1, n);
      apb(1'b0, 12'h008, 32'h0);
      chk(r, 32'h0040_0000 >> i, "reason");
      block_input <= 1'b0;
      recloser_enable_input <= 1'b1;
      waitv(2, 1'b1, n);
      if (i == 0) critical_request <= 1'b1;
      else lock_input <= 1'b1;
      waitv(3, 1'b1, n);
      critical_request <= 1'b0;
      lock_input <= 1'b0;
      if (i == 0) unlock;
      else begin
        wr(12'h000, 32'h0000_0019);
        waitv(3, 1'b0, n);
      end
    end
    $display("inhibit and lock test done");
    finish_test;
  end
endmodule // tb
`default_nettype wire
